// File: logic/hteq_defines.vh
// constants for the transmit event and dma request block
`ifndef HTEQ_DEFINES_VH
`define HTEQ_DEFINES_VH
// ************************************************************
// register byte offsets
// ************************************************************
`define HTEQ_OFS_CTRL    8'h00
`define HTEQ_OFS_XCNT    8'h04
`define HTEQ_OFS_EVT     8'h08
`define HTEQ_OFS_STAT    8'h0C
// ************************************************************
// control register fields
// ************************************************************
`define HTEQ_CTRL_DMA    0
`define HTEQ_CTRL_AUTO   1
`define HTEQ_CTRL_BUS    2
`define HTEQ_CTRL_CIE    3
`define HTEQ_CTRL_RST    8'h00
// ************************************************************
// event register bit positions
// ************************************************************
`define HTEQ_EV_XPR      0
`define HTEQ_EV_XMR      1
`define HTEQ_EV_XDU      2
`define HTEQ_EV_RSC      3
`define HTEQ_EV_PCE      4
`define HTEQ_EV_TIN      5
`define HTEQ_EV_CSC      6
`define HTEQ_EV_W        7
// ************************************************************
// sizes
// ************************************************************
`define HTEQ_POOL_BYTES  6'd32
`define HTEQ_CNT_W       12
`endif

// File: logic/hteq_evt_flags.v
// sticky event flags, cleared as a group by an event register read
`timescale 1ns/10ps
`include "hteq_defines.vh"
module hteq_evt_flags #(
  parameter W = `HTEQ_EV_W
) (
  // clock and reset
  input  wire         CLK,
  input  wire         RSTN,
  // events and clear
  input  wire [W-1:0] set,
  input  wire         clr,
  // flags
  output reg  [W-1:0] flags
);
  // set wins over the read clear so no event is lost
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      flags <= {W{1'b0}};
    end else if (clr) begin
      flags <= set;
    end else begin
      flags <= flags | set;
    end
  end
endmodule // hteq_evt_flags

// File: logic/hteq_top.v
// transmit events, special conditions and dma request for one channel
`timescale 1ns/10ps
`include "hteq_defines.vh"
module hteq_top #(
  parameter CW = `HTEQ_CNT_W
) (
  // clock and reset
  input  wire        CLK,
  input  wire        RSTN,
  // ahb-lite slave
  input  wire        HSEL,
  input  wire [7:0]  HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output wire [31:0] HRDATA,
  output wire        HREADYOUT,
  output wire        HRESP,
  // transmitter commands
  input  wire        TX_RESET_CMD,
  input  wire        SEND_TRANSPARENT_CMD,
  input  wire        SEND_IFRAME_CMD,
  input  wire        END_OF_MESSAGE_CMD,
  // serial side status
  input  wire        TX_BYTE_SHIFTED,
  input  wire        TX_SHIFT_IDLE,
  input  wire        TX_FRAME_DONE,
  input  wire        TX_HALF_RELEASED,
  input  wire        COLLISION,
  input  wire        CTS,
  // layer-2 receive side
  input  wire        RX_ACK_OK,
  input  wire        RX_ACK_BAD_NR,
  input  wire        RX_RR_FRAME,
  input  wire        RX_RNR_FRAME,
  input  wire        RX_S_WITH_INFO,
  input  wire        TIMER_EXPIRED,
  // receive fifo demand
  input  wire        RX_BLOCK_READY,
  input  wire [5:0]  RX_BLOCK_LEN,
  // dma
  input  wire        DMA_ACKNOWLEDGE,
  input  wire        DMA_RD,
  input  wire        DMA_WR,
  output wire        DMA_REQ_TRANSMIT,
  output wire        DMA_REQ_RECEIVE,
  // fifo access strobes
  output reg         FIFO_WR,
  output reg         FIFO_RD,
  // events
  output wire [6:0]  EVENTS,
  output wire        INT_ACTIVE
);
  // ************************************************************
  // bus slave
  // ************************************************************
  reg         ph_wr;
  reg         ph_rd;
  reg  [7:0]  ph_addr;
  reg  [7:0]  ctrl;
  reg  [CW:0] xcnt;
  reg  [31:0] rdata;
  wire        take = HSEL & HREADY & HTRANS[1];
  wire        wr_ctrl = ph_wr & (ph_addr == `HTEQ_OFS_CTRL);
  wire        wr_xcnt = ph_wr & (ph_addr == `HTEQ_OFS_XCNT);
  wire        rd_evt  = ph_rd & (ph_addr == `HTEQ_OFS_EVT);
  wire [6:0]  flags;
  wire        dma_mode = ctrl[`HTEQ_CTRL_DMA];
  wire        auto_md  = ctrl[`HTEQ_CTRL_AUTO];
  wire        bus_md   = ctrl[`HTEQ_CTRL_BUS];
  wire        cts_change_enable      = ctrl[`HTEQ_CTRL_CIE];

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata;

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_wr   <= take & HWRITE;
      ph_rd   <= take & ~HWRITE;
      ph_addr <= HADDR;
    end
  end

  // ************************************************************
  // transmit pool and message bookkeeping
  // ************************************************************
  reg        in_frame;
  reg        eom_seen;
  reg        transparent;
  reg        pool_free;
  reg [5:0]  tx_fill;
  reg [CW:0] shifted;
  reg        past32;
  reg        cts_d;
  reg        r_ready;
  reg        tx_req;
  reg        rx_req;
  reg [5:0]  rx_left;

  // dma end indication from byte count compare
  wire cnt_eom = dma_mode & (shifted == xcnt) & in_frame;
  wire message_end_indication     = eom_seen | cnt_eom;
  wire start   = SEND_TRANSPARENT_CMD | SEND_IFRAME_CMD;

  wire ev_xpr = TX_RESET_CMD
              | (~dma_mode & in_frame & ~eom_seen
                 & TX_HALF_RELEASED)
              | (~dma_mode & eom_seen & transparent
                 & TX_FRAME_DONE)
              | (auto_md & RX_ACK_OK);
  wire ev_xmr = (auto_md & RX_ACK_BAD_NR)
              | (bus_md & past32 & COLLISION)
              | (~bus_md & past32 & cts_d & ~CTS);
  wire ev_xdu = in_frame & (tx_fill == 6'd0)
              & TX_SHIFT_IDLE & ~message_end_indication;
  wire ev_rsc = auto_md & ((RX_RR_FRAME & ~r_ready)
              | (RX_RNR_FRAME & r_ready));
  wire ev_pce = auto_md & (RX_ACK_BAD_NR | RX_S_WITH_INFO);
  wire ev_tin = TIMER_EXPIRED;
  wire ev_csc = cts_change_enable & (cts_d ^ CTS);

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl        <= `HTEQ_CTRL_RST;
      xcnt        <= {(CW+1){1'b0}};
      in_frame    <= 1'b0;
      eom_seen    <= 1'b0;
      transparent <= 1'b0;
      pool_free   <= 1'b1;
      tx_fill     <= 6'd0;
      shifted     <= {(CW+1){1'b0}};
      past32      <= 1'b0;
      cts_d       <= 1'b0;
      r_ready     <= 1'b1;
    end else begin
      cts_d <= CTS;
      if (wr_ctrl) begin
        ctrl <= HWDATA[7:0];
      end
      if (wr_xcnt) begin
        xcnt <= HWDATA[CW:0];
      end
      if (RX_RR_FRAME) begin
        r_ready <= 1'b1;
      end else if (RX_RNR_FRAME) begin
        r_ready <= 1'b0;
      end
      if (TX_RESET_CMD) begin
        in_frame  <= 1'b0;
        eom_seen  <= 1'b0;
        pool_free <= 1'b1;
        tx_fill   <= 6'd0;
        shifted   <= {(CW+1){1'b0}};
        past32    <= 1'b0;
      end else begin
        if (start) begin
          in_frame    <= 1'b1;
          eom_seen    <= 1'b0;
          transparent <= SEND_TRANSPARENT_CMD;
          shifted     <= {(CW+1){1'b0}};
          past32      <= 1'b0;
        end else if (TX_FRAME_DONE) begin
          in_frame <= 1'b0;
        end
        if (END_OF_MESSAGE_CMD & ~dma_mode) begin
          eom_seen <= 1'b1;
        end
        if (TX_BYTE_SHIFTED & ~start) begin
          shifted <= shifted + {{CW{1'b0}}, 1'b1};
          if (shifted[5:0] == 6'd31 || shifted[CW:6] != 0) begin
            past32 <= 1'b1;
          end
        end
        // count the write in its own cycle so the last-write compare
        // sees every earlier write, even back to back
        if (DMA_WR) begin
          tx_fill <= tx_fill + 6'd1;
          if (tx_fill == `HTEQ_POOL_BYTES - 6'd1) begin
            pool_free <= 1'b0;
          end
        end else if (TX_BYTE_SHIFTED & tx_fill != 6'd0) begin
          tx_fill <= tx_fill - 6'd1;
        end
        if (TX_HALF_RELEASED) begin
          pool_free <= 1'b1;
          tx_fill   <= 6'd0;
        end
      end
    end
  end

  // ************************************************************
  // dma request handshake
  // ************************************************************
  // a cycle counts on its strobe alone; the acknowledge is not looked at
  wire acc_wr = DMA_WR;
  wire acc_rd = DMA_RD;
  wire tx_last = acc_wr & (tx_fill == `HTEQ_POOL_BYTES - 6'd1);
  wire rx_last = acc_rd & (rx_left == 6'd1);

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_req  <= 1'b0;
      rx_req  <= 1'b0;
      rx_left <= 6'd0;
      FIFO_WR <= 1'b0;
      FIFO_RD <= 1'b0;
    end else begin
      FIFO_WR <= acc_wr;
      FIFO_RD <= acc_rd;
      // target synchronous: stays up until the closing write, a transmit reset command or dma mode being switched off
      if (!dma_mode || TX_RESET_CMD || tx_last) begin
        tx_req <= 1'b0;
      end else if (pool_free & in_frame & ~message_end_indication) begin
        tx_req <= 1'b1;
      end
      if (!dma_mode) begin
        rx_req  <= 1'b0;
        rx_left <= 6'd0;
      end else if (RX_BLOCK_READY & ~rx_req) begin
        rx_req  <= 1'b1;
        rx_left <= RX_BLOCK_LEN;
      end else if (acc_rd & rx_req) begin
        rx_left <= rx_left - 6'd1;
        if (rx_last) begin
          rx_req <= 1'b0;
        end
      end
    end
  end

  // dropped combinationally the moment the last cycle starts
  assign DMA_REQ_TRANSMIT = tx_req & ~tx_last;
  assign DMA_REQ_RECEIVE  = rx_req & ~rx_last;

  // ************************************************************
  // events and status readback
  // ************************************************************
  hteq_evt_flags #(
    .W (7)
  ) u_flags (
    .CLK   (CLK),
    .RSTN  (RSTN),
    .set   ({ev_csc, ev_tin, ev_pce, ev_rsc, ev_xdu, ev_xmr, ev_xpr}),
    .clr   (rd_evt),
    .flags (flags)
  );

  assign EVENTS     = flags;
  assign INT_ACTIVE = |flags;

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata <= 32'h00000000;
    end else if (take & ~HWRITE) begin
      case (HADDR)
        `HTEQ_OFS_CTRL: rdata <= {24'h000000, ctrl};
        `HTEQ_OFS_XCNT: rdata <= {{(31-CW){1'b0}}, xcnt};
        `HTEQ_OFS_EVT:  rdata <= {25'h0000000, flags};
        `HTEQ_OFS_STAT: rdata <= {22'h000000, rx_req, tx_req,
                                  past32, message_end_indication, in_frame, tx_fill[4:0]};
        default:        rdata <= 32'h00000000;
      endcase
    end
  end
endmodule // hteq_top

// File: dv/hteq_monitor.sv
// assertions on the transmit event and dma request block
`timescale 1ns/10ps
`include "hteq_defines.vh"
module hteq_monitor (
  // clock and reset
  input logic       CLK,
  input logic       RSTN,
  // bus
  input logic       HSEL,
  input logic [7:0] HADDR,
  input logic [1:0] HTRANS,
  input logic       HWRITE,
  // causes
  input logic       RX_RR_FRAME,
  input logic       RX_RNR_FRAME,
  input logic       RX_ACK_BAD_NR,
  input logic       RX_S_WITH_INFO,
  input logic       TIMER_EXPIRED,
  input logic       RX_BLOCK_READY,
  // dma and events
  input logic       DMA_ACKNOWLEDGE,
  input logic       DMA_WR,
  input logic       DMA_REQ_TRANSMIT,
  input logic       DMA_REQ_RECEIVE,
  input logic       FIFO_WR,
  input logic [6:0] EVENTS,
  input logic       INT_ACTIVE
);
  logic       rd_evt;
  logic [5:0] wcnt;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // writes seen while the transmit request stands
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_evt <= 1'h0;
      wcnt   <= 6'h00;
    end else begin
      rd_evt <= HSEL && HTRANS[1] && !HWRITE && HADDR == `HTEQ_OFS_EVT;
      wcnt   <= DMA_REQ_TRANSMIT ? wcnt + {5'h00, DMA_WR} : 6'h00;
    end
  end
  sequence ack_wr_s;
    DMA_ACKNOWLEDGE && DMA_WR;
  endsequence
  sequence rx_rise_s;
    $rose(DMA_REQ_RECEIVE);
  endsequence
  int_line_a: assert property (INT_ACTIVE == |EVENTS)
    else $error("interrupt differs from event flags");
  evt_sticky_a: assert property ((|($past(EVENTS) & ~EVENTS))
    |-> $past(rd_evt)) else $error("event flag dropped without read");
  peer_stat_a: assert property ($rose(EVENTS[3])
    |-> $past(RX_RR_FRAME) || $past(RX_RNR_FRAME))
    else $error("peer status event without cause");
  proto_err_a: assert property ($rose(EVENTS[4])
    |-> $past(RX_ACK_BAD_NR) || $past(RX_S_WITH_INFO))
    else $error("protocol error event without cause");
  timer_evt_a: assert property (TIMER_EXPIRED |=> EVENTS[5])
    else $error("timer event missing");
  tx_block_a: assert property (DMA_WR && DMA_REQ_TRANSMIT
    |-> wcnt < 6'h1F) else $error("request held past last write");
  rx_req_a: assert property (rx_rise_s |-> $past(RX_BLOCK_READY))
    else $error("receive request without pending block");
  fifo_top_a: assert property (ack_wr_s |=> FIFO_WR)
    else $error("acknowledged write missed the fifo");
endmodule // hteq_monitor

bind hteq_top hteq_monitor u_mon (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .RX_RR_FRAME(RX_RR_FRAME), .RX_RNR_FRAME(RX_RNR_FRAME),
  .RX_ACK_BAD_NR(RX_ACK_BAD_NR), .RX_S_WITH_INFO(RX_S_WITH_INFO),
  .TIMER_EXPIRED(TIMER_EXPIRED), .RX_BLOCK_READY(RX_BLOCK_READY),
  .DMA_ACKNOWLEDGE(DMA_ACKNOWLEDGE), .DMA_WR(DMA_WR),
  .DMA_REQ_TRANSMIT(DMA_REQ_TRANSMIT), .DMA_REQ_RECEIVE(DMA_REQ_RECEIVE),
  .FIFO_WR(FIFO_WR), .EVENTS(EVENTS), .INT_ACTIVE(INT_ACTIVE));

// File: dv/hteq_dma_model.sv
// dma controller model serving transmit and receive requests
`timescale 1ns/10ps
module hteq_dma_model (
  // clock and reset
  input  logic       clk,
  input  logic       rstn,
  // requests and pacing
  input  logic       req_t,
  input  logic       req_r,
  input  logic       slow,
  // bus cycles
  output logic       wr,
  output logic       rd,
  output logic       ack,
  output logic [6:0] wcount,
  output logic [6:0] rcount
);
  // acknowledge on every cycle, so no address is ever needed
  // and the addressed fallback access is never used
  assign ack = wr || rd;
  // a cycle only starts on a standing request; slow leaves gaps
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr     <= 1'h0;
      rd     <= 1'h0;
      wcount <= 7'h00;
      rcount <= 7'h00;
    end else begin
      wr     <= req_t && !(slow && wr);
      rd     <= req_r && !req_t && !(slow && rd);
      wcount <= wcount + {6'h00, wr};
      rcount <= rcount + {6'h00, rd};
    end
  end
endmodule // hteq_dma_model

// File: dv/tb.sv
// self-checking bench for the transmit event and dma request block
`timescale 1ns/10ps
`include "hteq_defines.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic        clk, rstn, hsel, hwrite, cts, idle, rx_rdy, slow;
  logic [1:0]  htrans;
  logic [7:0]  haddr;
  logic [13:0] pls;
  logic [31:0] hwdata, rdat;
  wire  [31:0] hrdata;
  wire         hrdy, req_t, req_r, wr, rd, ack, int_act;
  wire  [6:0]  wcnt, rcnt, evts;
  int          fail_count, num_checks;
  // ctrl, cause (14 toggles cts), expected flags
  logic [15:0] row [9] = '{16'h0A00, 16'h2B08, 16'h2A08, 16'h2C10,
    16'h2912, 16'h2801, 16'h0D20, 16'h0E00, 16'h8E40};
  hteq_top DUT (.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(),
    .TX_RESET_CMD(pls[0]), .SEND_TRANSPARENT_CMD(pls[1]),
    .SEND_IFRAME_CMD(pls[2]), .END_OF_MESSAGE_CMD(pls[3]),
    .TX_BYTE_SHIFTED(pls[4]), .TX_SHIFT_IDLE(idle), .TX_FRAME_DONE(pls[5]),
    .TX_HALF_RELEASED(pls[6]), .COLLISION(pls[7]), .CTS(cts),
    .RX_ACK_OK(pls[8]), .RX_ACK_BAD_NR(pls[9]), .RX_RR_FRAME(pls[10]),
    .RX_RNR_FRAME(pls[11]), .RX_S_WITH_INFO(pls[12]),
    .TIMER_EXPIRED(pls[13]), .RX_BLOCK_READY(rx_rdy), .RX_BLOCK_LEN(6'h05),
    .DMA_ACKNOWLEDGE(ack), .DMA_RD(rd), .DMA_WR(wr),
    .DMA_REQ_TRANSMIT(req_t), .DMA_REQ_RECEIVE(req_r), .FIFO_WR(),
    .FIFO_RD(), .EVENTS(evts), .INT_ACTIVE(int_act));
  hteq_dma_model u_dma (.clk(clk), .rstn(rstn), .req_t(req_t),
    .req_r(req_r), .slow(slow), .wr(wr), .rd(rd), .ack(ack),
    .wcount(wcnt), .rcount(rcnt));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    @(posedge clk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'h1);
    rdat = hrdata;
  endtask
  task automatic pulse(input int n);
    @(posedge clk);
    pls <= 14'h0001 << n;
    @(posedge clk);
    pls <= 14'h0000;
  endtask
  // bounded wait until both requests and all cycles are over
  task automatic settle();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((req_t || req_r || wr || rd) && n < 300);
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
  // ************************************
  // main sequence
  // ************************************
  initial begin
    {hsel, hwrite, cts, idle, rx_rdy, slow, rstn} = 7'h00;
    {htrans, haddr, hwdata, pls} = 56'h0;
    fail_count = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    bus(0, `HTEQ_OFS_CTRL, 0);
    `CHK(rdat, 32'h0)
    pulse(0);
    bus(0, `HTEQ_OFS_EVT, 0);
    `CHK(rdat[0], 1'h1)
    bus(0, `HTEQ_OFS_EVT, 0);
    `CHK({rdat, int_act}, 33'h0)
    foreach (row[k]) begin
      bus(1, `HTEQ_OFS_CTRL, row[k][15:12]);
      if (row[k][11:8] == 4'hE) begin
        @(posedge clk);
        cts <= ~cts;
      end else pulse(row[k][11:8]);
      repeat (2) @(posedge clk);
      bus(0, `HTEQ_OFS_EVT, 0);
      `CHK(rdat, {24'h0, row[k][7:0]})
    end
    bus(1, `HTEQ_OFS_CTRL, 0);
    pulse(0);
    pulse(1);
    idle <= 1'h1;
    repeat (3) @(posedge clk);
    bus(0, `HTEQ_OFS_EVT, 0);
    `CHK(rdat[2], 1'h1)
    pulse(3);
    bus(0, `HTEQ_OFS_EVT, 0);
    bus(0, `HTEQ_OFS_EVT, 0);
    `CHK(rdat[2], 1'h0)
    pulse(5);
    idle <= 1'h0;
    bus(0, `HTEQ_OFS_EVT, 0);
    `CHK(rdat[0], 1'h1)
    // slow controller first, then a fast back-to-back block
    bus(1, `HTEQ_OFS_CTRL, 1);
    bus(1, `HTEQ_OFS_XCNT, 32'h40);
    slow <= 1'h1;
    pulse(0);
    pulse(1);
    repeat (3) @(posedge clk);
    settle();
    `CHK(wcnt, 7'h20)
    slow <= 1'h0;
    pulse(6);
    repeat (3) @(posedge clk);
    settle();
    `CHK(wcnt, 7'h40)
    rx_rdy <= 1'h1;
    repeat (2) @(posedge clk);
    rx_rdy <= 1'h0;
    settle();
    `CHK(rcnt, 7'h05)
    bus(1, `HTEQ_OFS_CTRL, 4);
    repeat (32) pulse(4);
    bus(0, `HTEQ_OFS_EVT, 0);
    pulse(7);
    bus(0, `HTEQ_OFS_EVT, 0);
    `CHK(rdat[1], 1'h1)
    bus(1, `HTEQ_OFS_CTRL, 0);
    cts <= 1'h1;
    repeat (2) @(posedge clk);
    bus(0, `HTEQ_OFS_EVT, 0);
    cts <= 1'h0;
    repeat (2) @(posedge clk);
    bus(0, `HTEQ_OFS_EVT, 0);
    `CHK(rdat[1], 1'h1)
    pulse(1);
    bus(0, `HTEQ_OFS_EVT, 0);
    pulse(6);
    bus(0, `HTEQ_OFS_EVT, 0);
    `CHK(rdat[0], 1'h1)
    end_of_test();
  end
endmodule // tb
